// *** bench/panel_model.sv ***
`timescale 1ns/1ps
module panel_model
(
    input  wire logic        clk,
    input  wire logic        cru_store_to_memory_start,
    input  wire logic        cru_in_stb,
    input  wire logic [15:0] switches,
    output logic             cru_in_bit
);
    logic [3:0] idx_ff = 4'h0;
    // unselected line shows the inverse so a stale bit never passes
    assign cru_in_bit = cru_in_stb ? switches[idx_ff] : ~switches[idx_ff];
    always_ff @(posedge clk)
        idx_ff <= cru_store_to_memory_start ? 4'h0 : idx_ff + {3'h0, cru_in_stb};
endmodule

// *** bench/testbench.sv ***
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0, rst_n = 1'b0, io_reset = 1'b0, restart_req_n = 1'b1, line_freq = 1'b0, idle_n = 1'b1;
    logic mem_error = 1'b0, fetch_stb = 1'b0, instr_end = 1'b0, trap_ack = 1'b0, return_with_workspace_stb = 1'b0, int_pres = 1'b0;
    logic cru_out_stb = 1'b0, cru_bit_out = 1'b0, cru_store_to_memory_start = 1'b0, cru_in_stb = 1'b0, wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0, wb_we_i = 1'b0, cru_in_bit, wb_ack_o, load_trap, st_load_stb, priv_error, err_int_req;
    logic rtc_int_req, int_accept, fault_lamp, run_lamp, power_lamp, idle_lamp_n, store_byte, store_done;
    logic [3:0] instr_class = 4'h0, trap_level = 4'h0, int_level = 4'h0, cru_store_to_memory_count = 4'h0, wb_adr_i = 4'h0;
    logic [3:0] wb_sel_i = 4'hf, rtc_int_level;
    logic [11:0] cru_addr = 12'h000;
    logic [15:0] status_word = 16'h0003, return_with_workspace_w15 = 16'h0000, trap_vector, st_load_val, store_data;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    int num_errors = 0, compares = 0;
    localparam logic [3:0]  ST_N[5]   = '{4'h3, 4'h8, 4'ha, 4'h0, 4'h1};
    localparam logic [15:0] ST_EXP[5] = '{16'h0005, 16'h00a5, 16'h02a5, 16'h12a5, 16'h0001};

    trap_panel_ctrl dut_u (.clk, .rst_n, .io_reset, .restart_req_n, .line_freq, .idle_n, .mem_error, .status_word,
        .fetch_stb, .instr_class, .instr_end, .trap_ack, .trap_level, .return_with_workspace_stb, .return_with_workspace_w15, .int_pres, .int_level,
        .cru_out_stb, .cru_addr, .cru_bit_out, .cru_store_to_memory_start, .cru_store_to_memory_count, .cru_in_stb, .cru_in_bit, .wb_cyc_i,
        .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .load_trap, .trap_vector,
        .st_load_stb, .st_load_val, .priv_error, .err_int_req, .rtc_int_req, .rtc_int_level, .int_accept,
        .fault_lamp, .run_lamp, .power_lamp, .idle_lamp_n, .store_data, .store_byte, .store_done);
    panel_model panel_u (.clk, .cru_store_to_memory_start, .cru_in_stb, .switches(16'h12a5), .cru_in_bit);

    initial
        forever #5 clk = ~clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop();
        if (num_errors == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic cru_wr(input logic [3:0] off, input logic b, input logic exp_err);
        @(posedge clk);
        cru_out_stb <= 1'b1;
        cru_addr <= trap_panel_pkg::PANEL_BASE + {8'h00, off};
        cru_bit_out <= b;
        @(posedge clk);
        cru_out_stb <= 1'b0;
        #1 chk(priv_error, exp_err);
    endtask

    task automatic fetch(input logic [3:0] cls, input logic exp_err);
        @(posedge clk);
        fetch_stb <= 1'b1;
        instr_class <= cls;
        @(posedge clk);
        fetch_stb <= 1'b0;
        #1 chk(priv_error, exp_err);
    endtask

    task automatic iend(input logic exp_trap);
        @(posedge clk);
        instr_end <= 1'b1;
        @(posedge clk);
        instr_end <= 1'b0;
        #1 chk(load_trap, exp_trap);
    endtask

    // ack is sampled at the edge, before the slave's own update lands
    task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] d);
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= d;
        do
            @(posedge clk);
        while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    initial
    begin
        #200us;
        num_errors++;
        report_and_stop();
    end

    initial
    begin
        repeat (20) @(posedge clk);
        chk({fault_lamp, run_lamp, power_lamp}, 3'b110);
        rst_n <= 1'b1;
        idle_n <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk({power_lamp, idle_lamp_n}, 2'b10);
        for (int i = 0; i < 5; i++)
        begin
            @(posedge clk);
            cru_store_to_memory_start <= 1'b1;
            cru_store_to_memory_count <= ST_N[i];
            @(posedge clk);
            cru_store_to_memory_start <= 1'b0;
            cru_in_stb <= 1'b1;
            repeat ((ST_N[i] == 4'h0) ? 16 : int'(ST_N[i])) @(posedge clk);
            cru_in_stb <= 1'b0;
            #1 chk({store_done, store_data}, {1'b1, ST_EXP[i]});
            chk(store_byte, ST_N[i] != 4'h0 && ST_N[i] <= 4'h8);
        end
        cru_wr(4'hb, 1'b0, 1'b0);
        chk(fault_lamp, 1'b0);
        cru_wr(4'he, 1'b1, 1'b0);
        chk(run_lamp, 1'b0);
        iend(1'b0);
        iend(1'b1);
        cru_wr(4'ha, 1'b0, 1'b0);
        chk(run_lamp, 1'b1);
        fetch(trap_panel_pkg::CLS_LOAD_RESTART_INSTR, 1'b0);
        iend(1'b1);
        chk({trap_vector, st_load_stb}, {trap_panel_pkg::LOAD_VECTOR, 1'b1});
        chk(st_load_val & 16'h010f, 16'h0000);
        @(posedge clk);
        restart_req_n <= 1'b0;
        repeat (4) @(posedge clk);
        #1 chk(run_lamp, 1'b0);
        iend(1'b1);
        iend(1'b0);
        @(posedge clk);
        restart_req_n <= 1'b1;
        int_pres <= 1'b1;
        int_level <= 4'h3;
        repeat (3) @(posedge clk);
        #1 chk(int_accept, 1'b1);
        @(posedge clk);
        int_level <= 4'h4;
        repeat (3) @(posedge clk);
        #1 chk(int_accept, 1'b0);
        wb(1'b1, trap_panel_pkg::REG_CONFIG, 32'h1);
        fetch(trap_panel_pkg::CLS_RTC_ENABLE_INSTR, 1'b0);
        @(posedge clk);
        line_freq <= 1'b1;
        repeat (3) @(posedge clk);
        #1 chk({rtc_int_req, rtc_int_level}, 5'h15);
        fetch(trap_panel_pkg::CLS_RTC_DISABLE_INSTR, 1'b0);
        fetch(trap_panel_pkg::CLS_RTC_ENABLE_INSTR, 1'b0);
        @(posedge clk);
        #1 chk(rtc_int_req, 1'b0);
        wb(1'b0, trap_panel_pkg::REG_STATUS, 32'h0);
        chk(rd[0], 1'b1);
        wb(1'b0, trap_panel_pkg::REG_CONFIG, 32'h0);
        chk(rd, 32'h1);
        wb(1'b0, 4'h8, 32'h0);
        chk(rd, 32'h0);
        status_word <= 16'h010f;
        cru_wr(4'hb, 1'b1, 1'b1);
        chk(fault_lamp, 1'b0);
        // classes 0 and 11 are ordinary; classes 1 to 10 and 12 trap in user mode
        for (int c = 0; c <= 12; c++)
            fetch(4'(c), c != 0 && c != 11);
        repeat (2) @(posedge clk);
        #1 chk(err_int_req, 1'b1);
        @(posedge clk);
        trap_ack <= 1'b1;
        trap_level <= 4'h2;
        @(posedge clk);
        trap_ack <= 1'b0;
        #1 chk(st_load_val & 16'h010f, 16'h0001);
        @(posedge clk);
        return_with_workspace_stb <= 1'b1;
        return_with_workspace_w15 <= 16'hfe70;
        @(posedge clk);
        return_with_workspace_stb <= 1'b0;
        #1 chk(st_load_val, (16'hfe70 & ~trap_panel_pkg::ST_RETURN_WITH_WORKSPACE_KEEP) | 16'h010f);
        @(posedge clk);
        status_word <= 16'h0003;
        mem_error <= 1'b1;
        repeat (3) @(posedge clk);
        mem_error <= 1'b0;
        #1 chk(err_int_req, 1'b1);
        cru_wr(4'hc, 1'b1, 1'b0);
        repeat (2) @(posedge clk);
        #1 chk(err_int_req, 1'b0);
        cru_wr(4'hb, 1'b1, 1'b0);
        chk(fault_lamp, 1'b1);
        @(posedge clk);
        io_reset <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk(fault_lamp, 1'b0);
        // power reset in mid-run must relight fault and run
        @(posedge clk);
        rst_n <= 1'b0;
        io_reset <= 1'b0;
        @(posedge clk);
        #1 chk({fault_lamp, run_lamp, power_lamp}, 3'b110);
        @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk({fault_lamp, power_lamp}, 2'b11);
        report_and_stop();
    end
endmodule

// *** logic/cru_store_if.sv ***
`timescale 1ns/1ps
interface cru_store_if;
    logic        start;
    logic [3:0]  count;
    logic        bit_stb;
    logic        bit_val;
    logic [15:0] data;
    logic        byte_mode;
    logic        done;

    modport ctrl   (output start, count, bit_stb, bit_val, input data, byte_mode, done);
    modport packer (input start, count, bit_stb, bit_val, output data, byte_mode, done);
endinterface

// *** logic/cru_store_packer.sv ***
`timescale 1ns/1ps
module cru_store_packer
(
    input  wire logic  clk,
    input  wire logic  rst_n,
    cru_store_if.packer sif
);
    typedef enum logic {PK_IDLE, PK_SHIFT} pk_state_t;

    typedef struct packed {
        pk_state_t   st;
        logic [4:0]  left;
        logic [3:0]  idx;
        logic [15:0] data;
        logic        byte_mode;
        logic        done;
    } pk_t;

    pk_t pk_ff;
    pk_t nxt_pk;

    always_comb
    begin
        nxt_pk      = pk_ff;
        nxt_pk.done = 1'b0;
        case (pk_ff.st)
            PK_IDLE:
            begin
                if (sif.start)
                begin
                    // count of zero means a full 16-bit field
                    nxt_pk.left      = (sif.count == 4'h0) ? 5'h10 : {1'b0, sif.count};
                    nxt_pk.idx       = 4'h0;
                    nxt_pk.data      = 16'h0000;
                    nxt_pk.byte_mode = (sif.count != 4'h0) && (sif.count <= 4'h8);
                    nxt_pk.st        = PK_SHIFT;
                end
            end
            PK_SHIFT:
            begin
                if (sif.bit_stb)
                begin
                    nxt_pk.data[pk_ff.idx] = sif.bit_val;
                    nxt_pk.idx             = pk_ff.idx + 4'h1;
                    nxt_pk.left            = pk_ff.left - 5'h01;
                    if (pk_ff.left == 5'h01)
                    begin
                        nxt_pk.done = 1'b1;
                        nxt_pk.st   = PK_IDLE;
                    end
                end
            end
            default:
            begin
                nxt_pk.st = PK_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pk_ff <= '{st: PK_IDLE, left: 5'h00, idx: 4'h0, data: 16'h0000, byte_mode: 1'b0, done: 1'b0};
        end
        else
        begin
            pk_ff <= nxt_pk;
        end
    end

    assign sif.data      = pk_ff.data;
    assign sif.byte_mode = pk_ff.byte_mode;
    assign sif.done      = pk_ff.done;

    AST_FIRST_BIT_LSB: assert property (@(posedge clk) disable iff (!rst_n)
        (pk_ff.st == PK_SHIFT && pk_ff.idx == 4'h0 && sif.bit_stb) |=> (pk_ff.data[0] == $past(sif.bit_val)))
        else $error("first cru bit not in lsb");
    AST_BYTE_ZERO_FILL: assert property (@(posedge clk) disable iff (!rst_n)
        pk_ff.done && pk_ff.byte_mode |-> (pk_ff.data[15:8] == 8'h00))
        else $error("byte store not zero filled");
endmodule

// *** logic/trap_panel_ctrl.sv ***
`timescale 1ns/1ps
module trap_panel_ctrl
#(
    parameter logic [1:0] RTC_ROUTE_RST = 2'h2
)
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        io_reset,
    input  wire logic        restart_req_n,
    input  wire logic        line_freq,
    input  wire logic        idle_n,
    input  wire logic        mem_error,
    input  wire logic [15:0] status_word,
    input  wire logic        fetch_stb,
    input  wire logic [3:0]  instr_class,
    input  wire logic        instr_end,
    input  wire logic        trap_ack,
    input  wire logic [3:0]  trap_level,
    input  wire logic        return_with_workspace_stb,
    input  wire logic [15:0] return_with_workspace_w15,
    input  wire logic        int_pres,
    input  wire logic [3:0]  int_level,
    input  wire logic        cru_out_stb,
    input  wire logic [11:0] cru_addr,
    input  wire logic        cru_bit_out,
    input  wire logic        cru_store_to_memory_start,
    input  wire logic [3:0]  cru_store_to_memory_count,
    input  wire logic        cru_in_stb,
    input  wire logic        cru_in_bit,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    output logic             load_trap,
    output logic [15:0]      trap_vector,
    output logic             st_load_stb,
    output logic [15:0]      st_load_val,
    output logic             priv_error,
    output logic             err_int_req,
    output logic             rtc_int_req,
    output logic [3:0]       rtc_int_level,
    output logic             int_accept,
    output logic             fault_lamp,
    output logic             run_lamp,
    output logic             power_lamp,
    output logic             idle_lamp_n,
    output logic [15:0]      store_data,
    output logic             store_byte,
    output logic             store_done
);
    generate
        if (RTC_ROUTE_RST > 2'h2)
        begin : g_bad_route
            $error("RTC_ROUTE_RST must be 0, 1 or 2");
        end
    endgenerate

    typedef struct packed {
        logic        rs1;
        logic        rs2;
        logic        rs_prev;
        logic        load_pend;
        logic        line_prev;
        logic        rtc_en;
        logic        rtc_pend;
        logic        rtc_req;
        logic [3:0]  rtc_lvl;
        logic [1:0]  route;
        logic        fault;
        logic        run;
        logic        err_pend;
        logic        mem_err;
        logic        err_req;
        logic [1:0]  step_cnt;
        logic        load_trap;
        logic [15:0] vec;
        logic        st_stb;
        logic [15:0] st_val;
        logic        priv_err;
        logic        accept;
        logic        power;
        logic        idle_n;
        logic        ack;
        logic [31:0] dat;
    } ctl_t;

    localparam ctl_t CTL_RST = '{
        rs1: 1'b1, rs2: 1'b1, rs_prev: 1'b1, load_pend: 1'b0, line_prev: 1'b0,
        rtc_en: 1'b0, rtc_pend: 1'b0, rtc_req: 1'b0, rtc_lvl: 4'h0, route: RTC_ROUTE_RST,
        fault: 1'b1, run: 1'b1, err_pend: 1'b0, mem_err: 1'b0, err_req: 1'b0,
        step_cnt: 2'h0, load_trap: 1'b0, vec: 16'h0000, st_stb: 1'b0, st_val: 16'h0000,
        priv_err: 1'b0, accept: 1'b0, power: 1'b0, idle_n: 1'b1, ack: 1'b0, dat: 32'h0000_0000};

    ctl_t c_ff;
    ctl_t nxt_c;

    cru_store_if sif ();

    cru_store_packer u_packer
    (
        .clk   (clk),
        .rst_n (rst_n),
        .sif   (sif)
    );

    assign sif.start   = cru_store_to_memory_start;
    assign sif.count   = cru_store_to_memory_count;
    assign sif.bit_stb = cru_in_stb;
    assign sif.bit_val = cru_in_bit;

    function automatic logic is_privileged(input logic [3:0] cls);
        case (cls)
            trap_panel_pkg::CLS_LOAD_MASK_IMMEDIATE,
            trap_panel_pkg::CLS_LOAD_MAP_FILE,
            trap_panel_pkg::CLS_LONG_DISTANCE_SOURCE,
            trap_panel_pkg::CLS_LONG_DISTANCE_DESTINATION,
            trap_panel_pkg::CLS_LOAD_RESTART_INSTR,
            trap_panel_pkg::CLS_RESET_INSTR,
            trap_panel_pkg::CLS_RTC_ENABLE_INSTR,
            trap_panel_pkg::CLS_RTC_DISABLE_INSTR,
            trap_panel_pkg::CLS_IDLE,
            trap_panel_pkg::CLS_CONTEXT_RETURN_INSTR: is_privileged = 1'b1;
            default:                                  is_privileged = 1'b0;
        endcase
    endfunction

    logic user_mode;
    logic restart_evt;
    logic fetch_ok;
    logic err_evt;
    logic cru_blocked;
    logic panel_hit;
    logic step_fire;
    logic wb_req;

    always_comb
    begin
        nxt_c          = c_ff;
        nxt_c.load_trap = 1'b0;
        nxt_c.st_stb   = 1'b0;
        nxt_c.priv_err = 1'b0;
        nxt_c.ack      = 1'b0;
        step_fire      = 1'b0;

        // only rs2 and its delayed copy rs_prev are looked at; rs1 is the metastability stage
        nxt_c.rs1     = restart_req_n;
        nxt_c.rs2     = c_ff.rs1;
        nxt_c.rs_prev = c_ff.rs2;
        restart_evt   = c_ff.rs_prev & ~c_ff.rs2;

        user_mode = status_word[trap_panel_pkg::ST_PRIV_IDX];
        fetch_ok  = fetch_stb && (instr_class != trap_panel_pkg::CLS_ILLEGAL)
                    && !(user_mode && is_privileged(instr_class));
        err_evt   = fetch_stb && !fetch_ok;

        // privileged cru writes from user mode are dropped as well as trapped
        cru_blocked = cru_out_stb && (cru_addr >= trap_panel_pkg::CRU_PRIV_MIN) && user_mode;
        panel_hit   = cru_out_stb && !cru_blocked
                      && (cru_addr[11:4] == trap_panel_pkg::PANEL_BASE[11:4]);
        err_evt     = err_evt || cru_blocked;
        nxt_c.priv_err = err_evt;

        // clock enable and clear; a line edge in the same cycle still sets
        if (fetch_ok && instr_class == trap_panel_pkg::CLS_RTC_ENABLE_INSTR)
        begin
            nxt_c.rtc_en = 1'b1;
        end
        if (fetch_ok && instr_class == trap_panel_pkg::CLS_RTC_DISABLE_INSTR)
        begin
            nxt_c.rtc_en   = 1'b0;
            nxt_c.rtc_pend = 1'b0;
        end
        nxt_c.line_prev = line_freq;
        if (line_freq && !c_ff.line_prev)
        begin
            nxt_c.rtc_pend = 1'b1;
        end
        case (c_ff.route)
            trap_panel_pkg::RTC_ROUTE_LVL5:  nxt_c.rtc_lvl = trap_panel_pkg::LEVEL_RTC_LO;
            trap_panel_pkg::RTC_ROUTE_LVL15: nxt_c.rtc_lvl = trap_panel_pkg::LEVEL_RTC_HI;
            default:         nxt_c.rtc_lvl = trap_panel_pkg::MASK_ZERO;
        endcase
        nxt_c.rtc_req = c_ff.rtc_en && c_ff.rtc_pend && (nxt_c.rtc_lvl != trap_panel_pkg::MASK_ZERO);

        // single-step countdown on instruction ends
        if (instr_end && c_ff.step_cnt != 2'h0)
        begin
            nxt_c.step_cnt = c_ff.step_cnt - 2'h1;
            step_fire      = (c_ff.step_cnt == 2'h1);
        end

        // panel cru bits
        if (panel_hit)
        begin
            case (cru_addr[3:0])
                trap_panel_pkg::PANEL_FAULT:  nxt_c.fault = cru_bit_out;
                trap_panel_pkg::PANEL_RUN:    nxt_c.run = 1'b1;
                trap_panel_pkg::PANEL_MEMCLR: nxt_c.mem_err = 1'b0;
                trap_panel_pkg::PANEL_STEP:
                begin
                    nxt_c.step_cnt = trap_panel_pkg::STEP_DELAY;
                    nxt_c.run      = 1'b0;
                end
                default: nxt_c.fault = nxt_c.fault;
            endcase
        end
        if (io_reset)
        begin
            nxt_c.fault = 1'b0;
        end
        if (!c_ff.rs2)
        begin
            nxt_c.run = 1'b0;
        end
        if (mem_error)
        begin
            nxt_c.mem_err = 1'b1;
        end

        // load trap at the instruction boundary, mask ignored
        if (instr_end && (c_ff.load_pend || step_fire))
        begin
            nxt_c.load_trap = 1'b1;
            nxt_c.load_pend = 1'b0;
            nxt_c.vec       = trap_panel_pkg::LOAD_VECTOR;
        end
        if (restart_evt || (fetch_ok && instr_class == trap_panel_pkg::CLS_LOAD_RESTART_INSTR))
        begin
            nxt_c.load_pend = 1'b1;
        end

        // new status word: load trap, other traps, then return
        if (nxt_c.load_trap)
        begin
            nxt_c.st_stb   = 1'b1;
            nxt_c.st_val   = {status_word[15:4], trap_panel_pkg::MASK_ZERO};
            nxt_c.st_val[trap_panel_pkg::ST_PRIV_IDX] = 1'b0;
        end
        else if (trap_ack)
        begin
            nxt_c.st_stb = 1'b1;
            nxt_c.st_val = {status_word[15:4],
                            (trap_level == 4'h0) ? trap_panel_pkg::MASK_ZERO : trap_level - 4'h1};
            nxt_c.st_val[trap_panel_pkg::ST_PRIV_IDX] = 1'b0;
        end
        else if (return_with_workspace_stb)
        begin
            nxt_c.st_stb = 1'b1;
            nxt_c.st_val = user_mode ? ((return_with_workspace_w15 & ~trap_panel_pkg::ST_RETURN_WITH_WORKSPACE_KEEP)
                                        | (status_word & trap_panel_pkg::ST_RETURN_WITH_WORKSPACE_KEEP))
                                     : return_with_workspace_w15;
        end
        if (trap_ack && trap_level == trap_panel_pkg::LEVEL_ERR)
        begin
            nxt_c.err_pend = 1'b0;
        end
        if (err_evt)
        begin
            nxt_c.err_pend = 1'b1;
        end
        nxt_c.err_req = c_ff.err_pend || c_ff.mem_err;
        nxt_c.accept  = int_pres && (int_level <= status_word[3:0]);
        nxt_c.power   = 1'b1;
        nxt_c.idle_n  = idle_n;

        // wishbone slave, one wait state, unmapped reads zero
        wb_req = wb_cyc_i && wb_stb_i && !c_ff.ack;
        if (wb_req)
        begin
            nxt_c.ack = 1'b1;
            if (wb_we_i && wb_sel_i[0] && wb_adr_i == trap_panel_pkg::REG_CONFIG)
            begin
                nxt_c.route = wb_dat_i[1:0];
            end
            case (wb_adr_i)
                trap_panel_pkg::REG_STATUS:
                    nxt_c.dat = {22'h000000, c_ff.step_cnt, c_ff.load_pend, c_ff.mem_err,
                                 c_ff.err_pend, c_ff.rtc_pend, c_ff.rtc_en, c_ff.run, c_ff.fault, c_ff.power};
                trap_panel_pkg::REG_CONFIG:
                    nxt_c.dat = {30'h00000000, c_ff.route};
                default:
                    nxt_c.dat = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            c_ff <= CTL_RST;
        end
        else
        begin
            c_ff <= nxt_c;
        end
    end

    assign wb_dat_o      = c_ff.dat;
    assign wb_ack_o      = c_ff.ack;
    assign load_trap     = c_ff.load_trap;
    assign trap_vector   = c_ff.vec;
    assign st_load_stb   = c_ff.st_stb;
    assign st_load_val   = c_ff.st_val;
    assign priv_error    = c_ff.priv_err;
    assign err_int_req   = c_ff.err_req;
    assign rtc_int_req   = c_ff.rtc_req;
    assign rtc_int_level = c_ff.rtc_lvl;
    assign int_accept    = c_ff.accept;
    assign fault_lamp    = c_ff.fault;
    assign run_lamp      = c_ff.run;
    assign power_lamp    = c_ff.power;
    assign idle_lamp_n   = c_ff.idle_n;
    assign store_data    = sif.data;
    assign store_byte    = sif.byte_mode;
    assign store_done    = sif.done;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_LOAD_AT_BOUNDARY: assert property (c_ff.load_pend && instr_end |=> load_trap)
        else $error("pending load not taken at boundary");
    AST_LOAD_CONTEXT: assert property (load_trap |-> st_load_stb
        && trap_vector == trap_panel_pkg::LOAD_VECTOR && st_load_val[3:0] == trap_panel_pkg::MASK_ZERO
        && !st_load_val[trap_panel_pkg::ST_PRIV_IDX])
        else $error("load trap context wrong");
    AST_PRIV_TRAP: assert property (fetch_stb && status_word[trap_panel_pkg::ST_PRIV_IDX]
        && instr_class == trap_panel_pkg::CLS_LOAD_MASK_IMMEDIATE |=> priv_error ##1 err_int_req)
        else $error("privileged op not trapped");
    AST_RETURN_WITH_WORKSPACE_EXEMPT: assert property (fetch_stb && !cru_out_stb
        && instr_class == trap_panel_pkg::CLS_RETURN_WITH_WORKSPACE |=> !priv_error)
        else $error("return trapped");
    AST_TRAP_PRIV_CLR: assert property (trap_ack
        |=> st_load_stb && !st_load_val[trap_panel_pkg::ST_PRIV_IDX])
        else $error("trap left user mode");
    AST_RETURN_WITH_WORKSPACE_KEEP: assert property (return_with_workspace_stb && !trap_ack && !nxt_c.load_trap
        && status_word[trap_panel_pkg::ST_PRIV_IDX] |=> (st_load_val & trap_panel_pkg::ST_RETURN_WITH_WORKSPACE_KEEP)
        == ($past(status_word) & trap_panel_pkg::ST_RETURN_WITH_WORKSPACE_KEEP))
        else $error("protected status bits loaded");
    AST_CRU_PRIV: assert property (cru_out_stb && cru_addr >= trap_panel_pkg::CRU_PRIV_MIN
        && status_word[trap_panel_pkg::ST_PRIV_IDX] |=> priv_error && ($stable(fault_lamp) || $past(io_reset)))
        else $error("privileged cru write allowed");
    AST_RTC_CLEAR: assert property (fetch_ok && instr_class == trap_panel_pkg::CLS_RTC_DISABLE_INSTR
        && !(line_freq && !c_ff.line_prev) |=> !c_ff.rtc_pend ##1 !rtc_int_req)
        else $error("clock off did not clear");
    AST_STEP_TWO: assert property (panel_hit && cru_addr[3:0] == trap_panel_pkg::PANEL_STEP && !instr_end
        |=> c_ff.step_cnt == trap_panel_pkg::STEP_DELAY)
        else $error("single step not armed for two");
    AST_INT_ACCEPT: assert property (int_pres && int_level > status_word[3:0] |=> !int_accept)
        else $error("masked interrupt accepted");
endmodule

// *** logic/trap_panel_pkg.sv ***
package trap_panel_pkg;

    // status word uses msb-first bit numbering; indexes below are vector positions
    localparam int unsigned ST_PRIV_IDX   = 8;          // status bit 7
    localparam logic [15:0] ST_RETURN_WITH_WORKSPACE_KEEP  = 16'h018f;   // status bits 7, 8, 12..15
    localparam logic [3:0]  MASK_ZERO     = 4'h0;
    localparam logic [3:0]  LEVEL_ERR     = 4'h2;
    localparam logic [3:0]  LEVEL_RTC_LO  = 4'h5;
    localparam logic [3:0]  LEVEL_RTC_HI  = 4'hf;
    localparam logic [15:0] LOAD_VECTOR   = 16'hfffc;

    // cru bit addresses
    localparam logic [11:0] CRU_PRIV_MIN  = 12'he00;
    localparam logic [11:0] PANEL_BASE    = 12'hff0;    // base 1fe0 as a bit address
    localparam logic [3:0]  PANEL_RUN     = 4'ha;
    localparam logic [3:0]  PANEL_FAULT   = 4'hb;
    localparam logic [3:0]  PANEL_MEMCLR  = 4'hc;
    localparam logic [3:0]  PANEL_STEP    = 4'he;
    localparam logic [1:0]  STEP_DELAY    = 2'h2;

    // register bus
    localparam logic [3:0]  REG_STATUS    = 4'h0;
    localparam logic [3:0]  REG_CONFIG    = 4'h4;

    typedef enum logic [1:0] {
        RTC_ROUTE_NONE,
        RTC_ROUTE_LVL5,
        RTC_ROUTE_LVL15
    } rtc_route_t;

    typedef enum logic [3:0] {
        CLS_OTHER,
        CLS_LOAD_MASK_IMMEDIATE,
        CLS_LOAD_MAP_FILE,
        CLS_LONG_DISTANCE_SOURCE,
        CLS_LONG_DISTANCE_DESTINATION,
        CLS_LOAD_RESTART_INSTR,
        CLS_RESET_INSTR,
        CLS_RTC_ENABLE_INSTR,
        CLS_RTC_DISABLE_INSTR,
        CLS_IDLE,
        CLS_CONTEXT_RETURN_INSTR,
        CLS_RETURN_WITH_WORKSPACE,
        CLS_ILLEGAL
    } instr_class_t;

endpackage
